// ### design/sar_converter_control.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "sar_consts.svh"
`default_nettype none
module sar_converter_control #(
    parameter int CONV_DIV = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Analog front end
    input wire logic comparator_high,
    output logic converter_power,
    output logic sample_hold,
    output logic [11:0] dac_code,
    output logic [9:0] analog_pin_route,
    output logic quarter_supply_route,
    output logic [9:0] pin_analog_select,
    // Interrupt
    output logic irq
);
    sar_pkg::ctl_state_t s, nxt;
    logic tick;
    logic trig;
    logic done_evt;
    logic [31:0] rd_word;
    logic rd_ok;

    function automatic logic [5:0] sample_len(input logic long_sel);
        sample_len = long_sel ? `SAMPLE_LONG : `SAMPLE_SHORT;
    endfunction

    // Conversion clock is a fixed divide of aclk, never tied to any system clock select
    assign tick = (s.div == 8'h00); // see RULE13

    always_comb begin
        rd_ok = 1'b1;
        case (araddr)
            `CTRL_ADDR: begin
                rd_word = {24'h00_0000, s.power, 1'b0, s.done_flag, s.sel};
            end
            `CFG_ADDR: begin
                rd_word = {15'h0000, s.long_samp, 6'h00, s.ain_sel};
            end
            `RESULT_ADDR: begin
                rd_word = {20'h0_0000, s.result};
            end
            `ISTAT_ADDR: begin
                rd_word = {31'h0000_0000, s.istat};
            end
            `IMASK_ADDR: begin
                rd_word = {31'h0000_0000, s.imask};
            end
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt = s;
        trig = 1'b0;
        done_evt = 1'b0;
        nxt.div = tick ? 8'(CONV_DIV - 1) : s.div - 8'h01;
        // Three-stage sync, change accepted once stages two and three agree
        nxt.s1 = comparator_high;
        nxt.s2 = s.s1;
        nxt.s3 = s.s2;
        if (s.s2 == s.s3) begin
            nxt.comp = s.s3;
        end
        case (s.state)
            sar_pkg::ST_IDLE: begin
            end
            sar_pkg::ST_SAMPLE: begin
                if (tick) begin
                    if (s.cnt == sample_len(s.long_samp) - 6'h01) begin // see RULE15
                        nxt.state = sar_pkg::ST_CONVERT;
                        nxt.cnt = 6'h00;
                        nxt.sar = `SAR_START;
                    end else begin
                        nxt.cnt = s.cnt + 6'h01;
                    end
                end
            end
            sar_pkg::ST_CONVERT: begin
                if (tick) begin
                    // One decision per step, MSB first; comparator high keeps the trial bit
                    if (s.cnt < {2'b00, `SAR_STEPS}) begin // see RULE12
                        if (!s.comp) begin
                            nxt.sar[4'hb - s.cnt[3:0]] = 1'b0;
                        end
                        if (s.cnt < {2'b00, `SAR_STEPS} - 6'h01) begin
                            nxt.sar[4'ha - s.cnt[3:0]] = 1'b1;
                        end
                    end
                    if (s.cnt == {2'b00, `CONVERT_TICKS} - 6'h01) begin // see RULE15
                        nxt.state = sar_pkg::ST_IDLE;
                        nxt.result = s.sar; // see RULE17
                        done_evt = 1'b1;
                    end else begin
                        nxt.cnt = s.cnt + 6'h01;
                    end
                end
            end
            default: begin
                nxt.state = sar_pkg::ST_IDLE;
            end
        endcase

        // Write channel: address and data taken in either order
        if (awvalid && !s.aw_h) begin
            nxt.aw_h = 1'b1;
            nxt.awaddr = awaddr;
        end
        if (wvalid && !s.w_h) begin
            nxt.w_h = 1'b1;
            nxt.wdata = wdata;
            nxt.wstrb0 = wstrb[0];
            // Lane one carries the upper analog-select bits and lane two the sample length
            nxt.wstrb_up = wstrb[1] | wstrb[2];
        end
        if (s.bvalid && bready) begin
            nxt.bvalid = 1'b0;
        end
        if (s.aw_h && s.w_h && !s.bvalid) begin
            nxt.aw_h = 1'b0;
            nxt.w_h = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = `RESP_OKAY;
            case (s.awaddr)
                `CTRL_ADDR: begin
                    if (s.wstrb0) begin
                        nxt.power = s.wdata[`CTRL_POWER_BIT]; // see RULE1
                        nxt.done_flag = s.wdata[`CTRL_DONE_BIT]; // see RULE8
                        nxt.sel = s.wdata[4:0];
                        // A one on the trigger bit acts only with the power bit also set in the same word; zero leaves the FSM alone
                        if (s.wdata[`CTRL_TRIG_BIT] && s.wdata[`CTRL_POWER_BIT]) begin // see RULE2
                            trig = 1'b1; // see RULE3
                        end
                    end
                end
                `CFG_ADDR: begin
                    if (s.wstrb0) begin
                        nxt.ain_sel[7:0] = s.wdata[7:0];
                    end
                    if (s.wstrb_up) begin
                        nxt.ain_sel[9:8] = s.wdata[9:8];
                        nxt.long_samp = s.wdata[`CFG_LONG_BIT];
                    end
                end
                `ISTAT_ADDR: begin
                    if (s.wstrb0 && s.wdata[0]) begin
                        nxt.istat = 1'b0;
                    end
                end
                `IMASK_ADDR: begin
                    if (s.wstrb0) begin
                        nxt.imask = s.wdata[0];
                    end
                end
                `RESULT_ADDR: begin
                end
                default: begin
                    nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end

        if (trig) begin
            nxt.state = sar_pkg::ST_SAMPLE;
            nxt.cnt = 6'h00;
            nxt.done_flag = 1'b0; // see RULE5
            done_evt = 1'b0;
        end
        if (!nxt.power) begin
            // Dropping power abandons any conversion in flight
            nxt.state = sar_pkg::ST_IDLE; // see RULE1
            done_evt = 1'b0;
        end
        if (done_evt) begin
            // Set wins over a register write clear landing in the same cycle; a trigger in that cycle cancels the set
            nxt.done_flag = 1'b1; // see RULE6
            nxt.istat = 1'b1; // see RULE7
        end

        // Read channel
        if (s.rvalid && rready) begin
            nxt.rvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            nxt.rvalid = 1'b1;
            nxt.rdata = rd_word;
            nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign awready = !s.aw_h;
    assign wready = !s.w_h;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign converter_power = s.power; // see RULE1
    assign sample_hold = (s.state == sar_pkg::ST_SAMPLE);
    assign dac_code = s.sar;
    always_comb begin
        analog_pin_route = 10'h000;
        quarter_supply_route = 1'b0;
        if (s.sel <= `SEL_PIN_LAST) begin
            analog_pin_route[s.sel[3:0]] = 1'b1; // see RULE9
        end else if (s.sel == `SEL_QUARTER) begin
            quarter_supply_route = 1'b1; // see RULE11
        end
        // Reserved codes leave every route open
    end
    // Port mux and pull-up control both follow this vector
    assign pin_analog_select = s.ain_sel; // see RULE14 see RULE16
    assign irq = s.istat & s.imask; // see RULE7

    logic ctrl_wr;
    assign ctrl_wr = s.aw_h && s.w_h && !s.bvalid && s.awaddr == `CTRL_ADDR && s.wstrb0;

    a_power_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE1
        s.state != sar_pkg::ST_IDLE |-> s.power)
        else $error("conversion running while unpowered");
    a_trigger_start: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE2
        ctrl_wr && s.wdata[7:6] == 2'b11 |=> s.state == sar_pkg::ST_SAMPLE && s.cnt == 6'h00)
        else $error("trigger did not start sampling");
    a_zero_trigger: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE3
        ctrl_wr && !s.wdata[6] && s.wdata[7] && s.state == sar_pkg::ST_IDLE
        |=> s.state == sar_pkg::ST_IDLE)
        else $error("zero trigger started conversion");
    a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE5
        ctrl_wr && s.wdata[7:6] == 2'b11 |=> !s.done_flag ##1 !s.done_flag)
        else $error("trigger left done flag set");
    a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE6
        s.done_flag && !ctrl_wr |=> s.done_flag)
        else $error("done flag dropped without software");
    a_irq_source: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE7
        $rose(s.done_flag) && !$past(ctrl_wr) |-> s.istat && (irq == s.imask))
        else $error("done flag not raised as interrupt");
    a_route_pin: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
        s.sel <= 5'h09 |-> $onehot(analog_pin_route) && !quarter_supply_route)
        else $error("pin code not routed");
    a_reserved_open: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE10
        s.sel > 5'h09 && s.sel < 5'h1f |-> analog_pin_route == 10'h000 && !quarter_supply_route)
        else $error("reserved code routed an input");
    a_quarter_tap: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE11
        s.sel == 5'h1f |-> quarter_supply_route && analog_pin_route == 10'h000)
        else $error("quarter tap not routed");
    a_convert_len: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE15
        $fell(s.state == sar_pkg::ST_CONVERT) && s.state == sar_pkg::ST_IDLE && s.power
        |-> s.cnt == {2'b00, `CONVERT_TICKS} - 6'h01)
        else $error("conversion phase length wrong");
    a_sample_len: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE15
        $rose(s.state == sar_pkg::ST_CONVERT)
        |-> $past(s.cnt) == ($past(s.long_samp) ? `SAMPLE_LONG : `SAMPLE_SHORT) - 6'h01)
        else $error("sample phase length wrong");
    a_done_sets: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE6
        s.state == sar_pkg::ST_CONVERT && tick && s.power && !ctrl_wr
        && s.cnt == {2'b00, `CONVERT_TICKS} - 6'h01 |=> s.done_flag && s.istat)
        else $error("conversion end did not set flags");
    a_result_first: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE17
        $rose(s.done_flag) && !$past(ctrl_wr) |-> s.result == dac_code && s.result == $past(s.sar))
        else $error("result not ready with done flag");

    c_short_conv: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.done_flag) && !s.long_samp);
    c_long_conv: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.done_flag) && s.long_samp);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_quarter_sel: cover property (@(posedge aclk) disable iff (!aresetn)
        quarter_supply_route);
endmodule
`default_nettype wire

// ### inc/sar_consts.svh
// Behaviour
// RULE1 - Power bit seven gates converter power
// RULE2 - Writing trigger one starts one conversion
// RULE3 - Writing trigger zero does nothing
// RULE4 - Software waits for done before rewriting
// RULE5 - Trigger clears the done flag
// RULE6 - Finish sets done flag, held until cleared
// RULE7 - Done flag is the interrupt request (code: irq is istat & imask, istat set with the flag)
// RULE8 - Software clears flag after interrupt
// RULE9 - Codes zero to nine route pin inputs
// RULE10 - Codes ten to thirty route nothing
// RULE11 - Code thirty-one routes quarter supply tap
// RULE12 - Twelve-bit result, one bit per step
// RULE13 - Converter clock from fixed internal divider
// RULE14 - Ten inputs share pins with ports
// RULE15 - Sample 6 or 36, then 14 clocks
// RULE16 - Analog select releases pin, drops pull-up
// RULE17 - Result updated no later than done flag
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define CTRL_INDEX 12'h0ad
`define CTRL_ADDR 12'h2b4
`define CFG_ADDR 12'h2b8
`define RESULT_ADDR 12'h2bc
`define ISTAT_ADDR 12'h2c0
`define IMASK_ADDR 12'h2c4
`define CTRL_POWER_BIT 7
`define CTRL_TRIG_BIT 6
`define CTRL_DONE_BIT 5
`define CFG_LONG_BIT 16
`define SEL_PIN_LAST 5'h09
`define SEL_QUARTER 5'h1f
`define SAMPLE_SHORT 6'h06
`define SAMPLE_LONG 6'h24
`define CONVERT_TICKS 4'he
`define SAR_STEPS 4'hc
`define SAR_START 12'h800
`define RESET_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### inc/sar_pkg.sv
`default_nettype none
package sar_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;
    typedef struct packed {
        conv_state_t state;
        logic power;
        logic done_flag;
        logic [4:0] sel;
        logic long_samp;
        logic [9:0] ain_sel;
        logic istat;
        logic imask;
        logic [11:0] result;
        logic [11:0] sar;
        logic [5:0] cnt;
        logic [7:0] div;
        logic s1;
        logic s2;
        logic s3;
        logic comp;
        logic aw_h;
        logic w_h;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic wstrb_up;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ctl_state_t;
endpackage
`default_nettype wire

// ### testbench/sar_converter_control_bench.sv
`include "sar_consts.svh"
`default_nettype none
module sar_converter_control_bench;
timeunit 1ns;
timeprecision 1ns;
localparam int CD = 2;
logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, comp_hi = 0;
logic [11:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h0000_0000;
logic [3:0] wstrb = 4'hf;
logic awready, wready, bvalid, arready, rvalid, cpwr, shold, qroute, irq;
logic [1:0] bresp, rresp, resp;
logic [31:0] rdata, rv;
logic [11:0] dac;
logic [9:0] route, pas;
int errors = 0, cmp_count = 0, cyc = 0;
sar_converter_control #(.CONV_DIV(CD)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .comparator_high(comp_hi), .converter_power(cpwr),
    .sample_hold(shold), .dac_code(dac), .analog_pin_route(route),
    .quarter_supply_route(qroute), .pin_analog_select(pas), .irq(irq));
always #20 aclk = ~aclk;
always @(posedge aclk) cyc <= cyc + 1;
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
        errors++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask
// Ready is sampled at the falling edge, so the handshake edge is known without a race
task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
        @(negedge aclk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid;
        resp = bresp;
        @(posedge aclk);
        if (ta) awvalid <= 0;
        if (tw) wvalid <= 0;
        n++;
    end while (!tb && n < 100);
    bready <= 0;
    if (n >= 100) errors++;
endtask
task rd(input logic [11:0] a);
    int n;
    logic ta, tb;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
        @(negedge aclk);
        ta = arvalid && arready;
        tb = rvalid;
        rv = rdata;
        resp = rresp;
        @(posedge aclk);
        if (ta) arvalid <= 0;
        n++;
    end while (!tb && n < 100);
    rready <= 0;
    if (n >= 100) errors++;
endtask
task t_reset;
    rd(`CTRL_ADDR);
    chk("ctrl reset", 32'h0000_0000, rv);
    chk("ctrl rresp", `RESP_OKAY, resp);
    chk("power reset", 0, cpwr);
    chk("route reset", 32'h0000_0001, route);
    chk("irq reset", 0, irq);
    $display("test reset done");
endtask
task t_route;
    for (int i = 0; i < 32; i++) begin
        wr(`CTRL_ADDR, i);
        chk("pin route", (i <= 9) ? (32'h0000_0001 << i) : 0, route);
        chk("quarter route", (i == 31), qroute);
    end
    $display("test route done");
endtask
task t_power;
    wr(`CTRL_ADDR, 32'h0000_0040);
    repeat (60) @(posedge aclk);
    chk("trigger unpowered", 0, cpwr);
    rd(`ISTAT_ADDR);
    chk("no conversion", 32'h0000_0000, rv);
    wr(`CTRL_ADDR, 32'h0000_0080);
    chk("power on", 1, cpwr);
    repeat (60) @(posedge aclk);
    chk("zero trigger idle", 0, shold);
    rd(`CTRL_ADDR);
    chk("zero trigger ctrl", 32'h0000_0080, rv);
    $display("test power done");
endtask
task conv(input logic c, input logic lng, input logic [11:0] e);
    int t0, ticks, n;
    ticks = (lng ? `SAMPLE_LONG : `SAMPLE_SHORT) + `CONVERT_TICKS;
    comp_hi <= c;
    wr(`CFG_ADDR, {15'h0000, lng, 16'h0001});
    chk("analog select", 32'h0000_0001, pas);
    wr(`CTRL_ADDR, 32'h0000_00e3);
    t0 = cyc;
    chk("trigger bresp", `RESP_OKAY, resp);
    rd(`CTRL_ADDR);
    chk("done cleared", 32'h0000_0083, rv);
    chk("route during", 32'h0000_0008, route);
    chk("sampling", 1, shold);
    n = 0;
    while (irq !== 1 && n < 2000) begin
        @(negedge aclk);
        n++;
    end
    n = cyc - t0;
    chk("conv length", 1, n >= ticks * CD - 4 && n <= ticks * CD + CD + 4);
    rd(`CTRL_ADDR);
    chk("done set", 32'h0000_00a3, rv);
    rd(`RESULT_ADDR);
    chk("result", e, rv);
    chk("dac code", e, dac);
    chk("irq raised", 1, irq);
    repeat (20) @(posedge aclk);
    rd(`CTRL_ADDR);
    chk("done held", 32'h0000_00a3, rv);
    $display("test conversion done");
endtask
task t_irq;
    wr(`IMASK_ADDR, 32'h0000_0000);
    chk("irq masked", 0, irq);
    wr(`IMASK_ADDR, 32'h0000_0001);
    chk("irq unmasked", 1, irq);
    wr(`ISTAT_ADDR, 32'h0000_0001);
    chk("irq cleared", 0, irq);
    wr(`CTRL_ADDR, 32'h0000_0083);
    rd(`CTRL_ADDR);
    chk("flag cleared", 32'h0000_0083, rv);
    $display("test irq done");
endtask
task t_unmapped;
    rd(12'h000);
    chk("unmapped rresp", `RESP_SLVERR, resp);
    chk("unmapped rdata", 32'h0000_0000, rv);
    wr(12'h004, 32'h0000_00ff);
    chk("unmapped bresp", `RESP_SLVERR, resp);
    $display("test unmapped done");
endtask
task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
initial begin
    #(40 * 40000);
    errors++;
    conclude;
end
initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_route;
    t_power;
    wr(`IMASK_ADDR, 32'h0000_0001);
    conv(1, 0, 12'hfff);
    t_irq;
    conv(0, 1, 12'h000);
    t_unmapped;
    conclude;
end
endmodule
`default_nettype wire
